//--- ext_access.v
`timescale 1ns/10ps
`default_nettype none
`include "ext_access_consts.vh"

module ext_access #(
  parameter MEM_AW    = 10,
  parameter [15:0] FIELD_LEN = `FIELD_LEN,
  parameter [15:0] DL_BASE   = `DL_BASE,
  parameter [15:0] PEND_CYC  = `DL_PEND_CYCLES
) (
  input  wire        i_clk_sys,
  input  wire        i_resetn,
  input  wire        i_cmd_valid,
  input  wire        i_cmd_write,
  input  wire [7:0]  i_cmd_reg,
  input  wire [15:0] i_cmd_data,
  input  wire [7:0]  i_cmd_chk,
  output reg         o_rsp_valid,
  output reg  [1:0]  o_rsp_status,
  output reg  [7:0]  o_rsp_reg,
  output reg  [15:0] o_rsp_data,
  output reg  [7:0]  o_rsp_chk,
  output reg  [31:0] o_pair_value,
  output reg         o_dl_busy
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rst_meta;
  reg rst_n;

  // async assert, two-flop release
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [7:0]  mem [0:(1<<MEM_AW)-1];
  reg [15:0] gen_cfg;
  reg [15:0] io_cap;
  reg [15:0] dl_cfg;
  reg [11:0] dl_count;
  reg [15:0] pend_cnt;
  reg        chk_armed;
  reg [7:0]  chk_prev;
  reg [15:0] rsp_prev;
  reg [15:0] pair_lo_held;
  reg [15:0] pair_hi_shadow;

  wire [15:0] auto_cfg;
  wire [15:0] auto_ptr;
  wire [23:0] auto_addr;
  wire [15:0] sec_cfg;
  wire [15:0] sec_ptr;
  wire [23:0] sec_addr;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  reg [1:0]  d_status;
  reg [15:0] d_data;
  reg        auto_load;
  reg [15:0] auto_base;
  reg        auto_cfg_we;
  reg        auto_ptr_we;
  reg        auto_step;
  reg        sec_load;
  reg        sec_cfg_we;
  reg        sec_ptr_we;
  reg        sec_step;
  reg        mem_we;
  reg [MEM_AW-1:0] mem_a;
  reg        gen_we;
  reg        io_cap_we;
  reg        dl_we;
  reg        dl_start;
  reg        arm_set;
  reg        pair_lo_we;
  reg        pair_hi_we;
  reg        pair_cap;

  wire [7:0] in_chk;
  wire       chk_bad;
  wire [MEM_AW-1:0] mem_a1;

  // inbound sum over flag byte, register and data bytes
  assign in_chk = {7'h00, i_cmd_write} + i_cmd_reg
                + i_cmd_data[15:8] + i_cmd_data[7:0];
  assign chk_bad = chk_armed && (in_chk != i_cmd_chk);
  assign mem_a1 = mem_a + {{(MEM_AW-1){1'b0}}, 1'b1};

  always @* begin
    d_status = `ST_OK;
    d_data = 16'h0000;
    auto_load = 1'b0;
    auto_base = 16'h0000;
    auto_cfg_we = 1'b0;
    auto_ptr_we = 1'b0;
    auto_step = 1'b0;
    sec_load = 1'b0;
    sec_cfg_we = 1'b0;
    sec_ptr_we = 1'b0;
    sec_step = 1'b0;
    mem_we = 1'b0;
    mem_a = {MEM_AW{1'b0}};
    gen_we = 1'b0;
    io_cap_we = 1'b0;
    dl_we = 1'b0;
    dl_start = 1'b0;
    arm_set = 1'b0;
    pair_lo_we = 1'b0;
    pair_hi_we = 1'b0;
    pair_cap = 1'b0;
    if (!i_cmd_valid) begin
      d_status = `ST_OK;
    end else if (chk_bad) begin
      d_status = `ST_XE;
    end else if (i_cmd_reg >= `REG_AUTO_FIRST &&
                 i_cmd_reg <= `REG_AUTO_LAST) begin
      // field length instead of data, either direction
      d_status = `ST_AUTO;
      d_data = FIELD_LEN;
      auto_load = 1'b1;
      auto_base = {i_cmd_reg - `REG_AUTO_FIRST, 8'h00}
                  >> (8 - `FIELD_SHIFT);
    end else begin
      case (i_cmd_reg)
        `REG_NOP: begin
          d_data = {8'h00, (o_dl_busy ? `PEND_BIT_DL : 4'h0), 4'h0};
        end
        `REG_GEN_CFG: begin
          d_data = gen_cfg;
          gen_we = i_cmd_write;
        end
        `REG_AUTO_CFG: begin
          d_data = auto_cfg;
          auto_cfg_we = i_cmd_write;
        end
        `REG_AUTO_PTR: begin
          d_data = auto_ptr;
          auto_ptr_we = i_cmd_write;
        end
        `REG_AUTO_WIN: begin
          mem_a = auto_addr[MEM_AW-1:0];
          d_data = {mem[mem_a], mem[mem_a1]};
          mem_we = i_cmd_write;
          auto_step = 1'b1;
        end
        `REG_IO_CAP: begin
          d_data = io_cap;
          io_cap_we = i_cmd_write;
        end
        `REG_SEC_CFG: begin
          d_data = sec_cfg;
          sec_cfg_we = i_cmd_write;
        end
        `REG_SEC_PTR: begin
          d_data = sec_ptr;
          sec_ptr_we = i_cmd_write;
        end
        `REG_SEC_WIN: begin
          mem_a = sec_addr[MEM_AW-1:0];
          d_data = {mem[mem_a], mem[mem_a1]};
          mem_we = i_cmd_write;
          sec_step = 1'b1;
        end
        `REG_CHK_ARM: begin
          if (i_cmd_write)
            arm_set = 1'b1;
          else
            d_status = `ST_XE;
        end
        `REG_RSP_CHK: begin
          d_data = {8'h00, chk_prev};
          if (i_cmd_write)
            d_status = `ST_XE;
        end
        `REG_PREV_RSP: begin
          d_data = rsp_prev;
          if (i_cmd_write)
            d_status = `ST_XE;
        end
        `REG_DL_CFG: begin
          d_data = dl_cfg;
          if (i_cmd_write && o_dl_busy) begin
            d_status = `ST_XE;
          end else if (i_cmd_write) begin
            dl_we = 1'b1;
            if (i_cmd_data[`DL_START_BIT]) begin
              dl_start = 1'b1;
              d_status = `ST_PEND;
              d_data = {8'h00, `PEND_BIT_DL, 4'h0};
            end
          end
        end
        `REG_DL_STAT: begin
          d_data = {o_dl_busy, 3'h0, dl_count};
          if (i_cmd_write)
            d_status = `ST_XE;
        end
        `REG_PAIR_LO: begin
          d_data = o_pair_value[15:0];
          pair_lo_we = i_cmd_write;
          pair_cap = !i_cmd_write;
        end
        `REG_PAIR_HI: begin
          d_data = pair_hi_shadow;
          pair_hi_we = i_cmd_write;
        end
        default: begin
          d_status = `ST_XE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // the two extended address triplets
  // ------------------------------------------------------------
  // kept apart so an auto access never disturbs a long
  // transfer running through the second triplet
  ext_window u_auto_win (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (rst_n),
    .i_cfg_we   (auto_cfg_we),
    .i_ptr_we   (auto_ptr_we),
    .i_wdata    (i_cmd_data),
    .i_load     (auto_load),
    .i_load_cfg (`CFG_STEP_BOTH),
    .i_load_ptr (auto_base),
    .i_step     (auto_step),
    .i_step_wr  (i_cmd_write),
    .o_cfg      (auto_cfg),
    .o_ptr      (auto_ptr),
    .o_addr     (auto_addr)
  );

  ext_window u_sec_win (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (rst_n),
    .i_cfg_we   (sec_cfg_we),
    .i_ptr_we   (sec_ptr_we),
    .i_wdata    (i_cmd_data),
    .i_load     (sec_load | dl_start),
    .i_load_cfg (`CFG_STEP_BOTH),
    .i_load_ptr (DL_BASE),
    .i_step     (sec_step),
    .i_step_wr  (i_cmd_write),
    .o_cfg      (sec_cfg),
    .o_ptr      (sec_ptr),
    .o_addr     (sec_addr)
  );

  // ------------------------------------------------------------
  // window memory
  // ------------------------------------------------------------
  // big-endian pair of bytes per window transfer
  always @(posedge i_clk_sys) begin
    if (mem_we) begin
      mem[mem_a] <= i_cmd_data[15:8];
      mem[mem_a1] <= i_cmd_data[7:0];
    end
  end

  // ------------------------------------------------------------
  // registers, response, pending download
  // ------------------------------------------------------------
  wire [7:0] out_chk;
  assign out_chk = {6'h00, d_status} + i_cmd_reg
                 + d_data[15:8] + d_data[7:0];

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_status <= `ST_OK;
      o_rsp_reg <= 8'h00;
      o_rsp_data <= 16'h0000;
      o_rsp_chk <= 8'h00;
      o_pair_value <= 32'h00000000;
      o_dl_busy <= 1'b0;
      gen_cfg <= 16'h0000;
      io_cap <= 16'h0000;
      dl_cfg <= 16'h0000;
      dl_count <= 12'h000;
      pend_cnt <= 16'h0000;
      chk_armed <= 1'b0;
      chk_prev <= 8'h00;
      rsp_prev <= 16'h0000;
      pair_lo_held <= 16'h0000;
      pair_hi_shadow <= 16'h0000;
    end else begin
      o_rsp_valid <= i_cmd_valid;
      if (i_cmd_valid) begin
        o_rsp_status <= d_status;
        o_rsp_reg <= i_cmd_reg;
        o_rsp_data <= d_data;
        o_rsp_chk <= out_chk;
        chk_prev <= out_chk;
        rsp_prev <= {6'h00, d_status, i_cmd_reg};
        // armed check is spent by the next packet only
        chk_armed <= arm_set;
      end
      if (gen_we)
        gen_cfg <= i_cmd_data;
      if (io_cap_we)
        io_cap <= i_cmd_data;
      if (dl_we)
        dl_cfg <= i_cmd_data;
      if (pair_lo_we)
        pair_lo_held <= i_cmd_data;
      if (pair_hi_we)
        o_pair_value <= {i_cmd_data, pair_lo_held};
      if (pair_cap)
        pair_hi_shadow <= o_pair_value[31:16];
      // pending operation runs a fixed time then clears
      if (dl_start) begin
        o_dl_busy <= 1'b1;
        pend_cnt <= PEND_CYC;
        dl_count <= 12'h000;
      end else if (o_dl_busy) begin
        pend_cnt <= pend_cnt - 16'h0001;
        if (pend_cnt == 16'h0001)
          o_dl_busy <= 1'b0;
      end
      if (sec_step && dl_cfg[`DL_START_BIT] && !dl_start)
        dl_count <= dl_count + 12'h002;
    end
  end

endmodule
`default_nettype wire

//--- ext_access_consts.vh
// Contract
// - pending response carries one-hot bit 4..7
// - lower pair read captures whole value
// - lower pair write only held
// - upper pair write commits combined value
// - auto access returns field byte length
// - auto access sets status value two
// - device preloads auto triplet on access
// - odd length leaves last byte undefined
// - host configures second triplet, window 0x10
// - download start preloads second triplet
// - auto triplet independent of second triplet
// - config holds read/write step flags, high bits
// - pointer is 16 bits, selects location
// - checksum write arms next command check
// - 0x12 returns previous response checksum
// - 0x16-0x1f reserved, 0x20+ device specific
// - status two means data holds byte count
`ifndef EXT_ACCESS_CONSTS_VH
`define EXT_ACCESS_CONSTS_VH

// ------------------------------------------------------------
// register numbers
// ------------------------------------------------------------
`define REG_NOP        8'h00
`define REG_AUTO_FIRST 8'h01
`define REG_AUTO_LAST  8'h07
`define REG_GEN_CFG    8'h08
`define REG_AUTO_CFG   8'h09
`define REG_AUTO_PTR   8'h0a
`define REG_AUTO_WIN   8'h0b
`define REG_IO_CAP     8'h0d
`define REG_SEC_CFG    8'h0e
`define REG_SEC_PTR    8'h0f
`define REG_SEC_WIN    8'h10
`define REG_CHK_ARM    8'h11
`define REG_RSP_CHK    8'h12
`define REG_PREV_RSP   8'h13
`define REG_DL_CFG     8'h14
`define REG_DL_STAT    8'h15
`define REG_PAIR_LO    8'h20
`define REG_PAIR_HI    8'h21

// ------------------------------------------------------------
// response status codes and fields
// ------------------------------------------------------------
`define ST_OK          2'h0
`define ST_XE          2'h1
`define ST_AUTO        2'h2
`define ST_PEND        2'h3
`define PEND_BIT_DL    4'h1
`define CFG_RD_INC     0
`define CFG_RD_DEC     1
`define CFG_WR_INC     2
`define CFG_WR_DEC     3
`define CFG_HI_LSB     8
`define CFG_STEP_BOTH  16'h0005
`define DL_START_BIT   0
`define ADDR_STEP      24'h000002

// ------------------------------------------------------------
// timing and layout defaults
// ------------------------------------------------------------
`define DL_PEND_CYCLES 16'h0064
`define FIELD_SHIFT    7
`define FIELD_LEN      16'h0050
`define DL_BASE        16'h0200

`endif

//--- ext_window.v
`timescale 1ns/10ps
`default_nettype none
`include "ext_access_consts.vh"

// one extended address triplet: config, pointer, stepping
module ext_window (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_cfg_we,
  input  wire        i_ptr_we,
  input  wire [15:0] i_wdata,
  input  wire        i_load,
  input  wire [15:0] i_load_cfg,
  input  wire [15:0] i_load_ptr,
  input  wire        i_step,
  input  wire        i_step_wr,
  output reg  [15:0] o_cfg,
  output reg  [15:0] o_ptr,
  output wire [23:0] o_addr
);

  wire        up;
  wire        down;
  wire [23:0] next_addr;

  // step flags chosen by direction of access
  assign up = i_step_wr ? o_cfg[`CFG_WR_INC] : o_cfg[`CFG_RD_INC];
  assign down = i_step_wr ? o_cfg[`CFG_WR_DEC] : o_cfg[`CFG_RD_DEC];
  assign o_addr = {o_cfg[15:`CFG_HI_LSB], o_ptr};
  assign next_addr = up ? o_addr + `ADDR_STEP :
                     down ? o_addr - `ADDR_STEP : o_addr;

  // preload beats host writes; step carries into high bits
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg <= 16'h0000;
      o_ptr <= 16'h0000;
    end else if (i_load) begin
      o_cfg <= i_load_cfg;
      o_ptr <= i_load_ptr;
    end else if (i_step) begin
      o_cfg[15:`CFG_HI_LSB] <= next_addr[23:16];
      o_ptr <= next_addr[15:0];
    end else begin
      if (i_cfg_we)
        o_cfg <= i_wdata;
      if (i_ptr_we)
        o_ptr <= i_wdata;
    end
  end

endmodule
`default_nettype wire

//--- host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// host side: one command packet at a time
// ----------------------------------------
module host_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rsp_valid,
  input  wire logic [1:0]  i_rsp_status,
  input  wire logic [15:0] i_rsp_data,
  input  wire logic [7:0]  i_rsp_chk,
  output var  logic        o_cmd_valid,
  output var  logic        o_cmd_write,
  output var  logic [7:0]  o_cmd_reg,
  output var  logic [15:0] o_cmd_data,
  output var  logic [7:0]  o_cmd_chk
);
  logic        hung;
  logic [1:0]  st;
  logic [15:0] dat;
  logic [7:0]  ck;
  initial begin
    o_cmd_valid = 1'h0;
    o_cmd_write = 1'h0;
    o_cmd_reg = 8'h00;
    o_cmd_data = 16'h0000;
    o_cmd_chk = 8'h00;
    hung = 1'h0;
  end
  // drive at falling edge, hold across the taking edge, then await answer
  task xfer(input logic w, input logic [7:0] g, input logic [15:0] d, input logic bad);
    integer n;
    @(negedge i_clk_sys);
    o_cmd_valid = 1'h1;
    o_cmd_write = w;
    o_cmd_reg = g;
    o_cmd_data = d;
    o_cmd_chk = {7'h00, w} + g + d[15:8] + d[7:0] + {7'h00, bad}; // bad spoils sum
    @(negedge i_clk_sys);
    // idle lines show the inverse, so a stale copy never looks valid
    o_cmd_valid = 1'h0;
    o_cmd_write = ~w;
    o_cmd_reg = ~g;
    o_cmd_data = ~d;
    o_cmd_chk = ~o_cmd_chk;
    for (n = 0; n < 8 && i_rsp_valid !== 1'h1; n = n + 1) @(negedge i_clk_sys);
    hung = (i_rsp_valid !== 1'h1);
    st = i_rsp_status;
    dat = i_rsp_data;
    ck = i_rsp_chk;
  endtask
endmodule
`default_nettype wire

//--- ext_access_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ext_access_checker #(
  parameter [15:0] FIELD_LEN = 16'h0050,
  parameter [15:0] PEND_CYC  = 16'h0064
) (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire logic        i_cmd_valid,
  input wire logic        i_cmd_write,
  input wire logic [7:0]  i_cmd_reg,
  input wire logic [15:0] i_cmd_data,
  input wire logic [7:0]  i_cmd_chk,
  input wire logic        o_rsp_valid,
  input wire logic [1:0]  o_rsp_status,
  input wire logic [7:0]  o_rsp_reg,
  input wire logic [15:0] o_rsp_data,
  input wire logic [7:0]  o_rsp_chk,
  input wire logic [31:0] o_pair_value,
  input wire logic        o_dl_busy
);
  logic [7:0]  cmd_sum;
  logic [7:0]  rsp_sum;
  logic        ok;
  logic [15:0] busy_cnt;
  // packet sums mod 256; auto, pair commit, download start and status antecedents need a good sum so arming never matters
  assign cmd_sum = {7'h00, i_cmd_write} + i_cmd_reg + i_cmd_data[15:8] + i_cmd_data[7:0];
  assign rsp_sum = {6'h00, o_rsp_status} + o_rsp_reg + o_rsp_data[15:8] + o_rsp_data[7:0];
  assign ok = i_cmd_valid && (cmd_sum == i_cmd_chk);
  // length of the current busy stretch
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= o_dl_busy ? busy_cnt + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence s_auto_req;
    ok && i_cmd_reg >= 8'h01 && i_cmd_reg <= 8'h07;
  endsequence
  sequence s_auto_rsp;
    o_rsp_valid && o_rsp_status == 2'h2 && o_rsp_data == FIELD_LEN;
  endsequence
  a_auto_length: assert property (s_auto_req |=> s_auto_rsp)
    else $error("auto access gave no length");
  a_answer_echo: assert property (i_cmd_valid |=> o_rsp_valid && o_rsp_reg == $past(i_cmd_reg))
    else $error("response missing or wrong register");
  a_no_spurious: assert property (!i_cmd_valid |=> !o_rsp_valid)
    else $error("response without command");
  a_rsp_sum: assert property (o_rsp_valid |-> o_rsp_chk == rsp_sum)
    else $error("response checksum wrong");
  a_pend_onehot: assert property (o_rsp_valid && o_rsp_status == 2'h3 |->
      o_rsp_data[15:8] == 8'h00 && o_rsp_data[3:0] == 4'h0 && $onehot(o_rsp_data[7:4]))
    else $error("pending word not one-hot");
  a_pair_held: assert property (i_cmd_valid && i_cmd_write && i_cmd_reg == 8'h20 |=> $stable(o_pair_value))
    else $error("lower pair write changed value");
  a_pair_commit: assert property (ok && i_cmd_write && i_cmd_reg == 8'h21 |=>
      o_pair_value[31:16] == $past(i_cmd_data))
    else $error("upper pair write not committed");
  a_dl_start: assert property (ok && i_cmd_write && i_cmd_reg == 8'h14 && i_cmd_data[0] && !o_dl_busy
      |=> o_rsp_status == 2'h3 ##0 o_dl_busy)
    else $error("download start not pending");
  a_busy_bound: assert property (o_dl_busy |-> busy_cnt < PEND_CYC)
    else $error("pending operation too long");
  a_busy_ends: assert property (o_dl_busy && busy_cnt == PEND_CYC - 16'h0001 |=>
      !o_dl_busy)
    else $error("pending operation did not end");
  a_nop_pending: assert property (ok && !i_cmd_write && i_cmd_reg == 8'h00 && o_dl_busy
      |=> o_rsp_data == 16'h0010)
    else $error("pending bit missing from status word");
  a_reserved_err: assert property (i_cmd_valid && (i_cmd_reg == 8'h0c ||
      (i_cmd_reg >= 8'h16 && i_cmd_reg <= 8'h1f)) |=> o_rsp_status == 2'h1)
    else $error("reserved register accepted");
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk;
  logic        resetn;
  logic        cv;
  logic        cw;
  logic [7:0]  cr;
  logic [15:0] cd;
  logic [7:0]  cc;
  logic        rv;
  logic [1:0]  rs;
  logic [7:0]  rg;
  logic [15:0] rd_d;
  logic [7:0]  rc;
  logic [31:0] pv;
  logic        busy;
  integer      seed;
  integer      n_fail;
  integer      n_checks;
  integer      i;
  logic [15:0] a;
  logic [15:0] b;
  logic [31:0] c;
  logic [7:0]  r;
  ext_access #(.PEND_CYC(16'h0028)) ext_access_inst (.i_clk_sys(clk), .i_resetn(resetn),
    .i_cmd_valid(cv), .i_cmd_write(cw), .i_cmd_reg(cr), .i_cmd_data(cd), .i_cmd_chk(cc),
    .o_rsp_valid(rv), .o_rsp_status(rs), .o_rsp_reg(rg), .o_rsp_data(rd_d), .o_rsp_chk(rc),
    .o_pair_value(pv), .o_dl_busy(busy));
  host_model host_inst (.i_clk_sys(clk), .i_rsp_valid(rv), .i_rsp_status(rs),
    .i_rsp_data(rd_d), .i_rsp_chk(rc), .o_cmd_valid(cv), .o_cmd_write(cw), .o_cmd_reg(cr),
    .o_cmd_data(cd), .o_cmd_chk(cc));
  initial clk = 1'h0;
  always #50 clk = ~clk;
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
      n_fail = n_fail + 1;
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] rsum(input logic [1:0] s, input logic [7:0] g, input logic [15:0] d);
    rsum = {6'h00, s} + g + d[15:8] + d[7:0];
  endfunction
  // one command; status always compared, data only when dk is set
  task cmd(input logic w, input logic [7:0] g, input logic [15:0] d, input logic bad,
           input logic [1:0] st, input logic dk, input logic [15:0] dx);
    host_inst.xfer(w, g, d, bad);
    if (host_inst.hung) begin
      n_fail = n_fail + 1;
      summarize();
    end
    check(host_inst.st, st);
    if (dk) check(host_inst.dat, dx);
    check(host_inst.ck, rsum(host_inst.st, g, host_inst.dat));
  endtask
  task rd(input logic [7:0] g, input logic [15:0] dx);
    cmd(1'h0, g, 16'h0000, 1'h0, 2'h0, 1'h1, dx);
  endtask
  task wr(input logic [7:0] g, input logic [15:0] d);
    cmd(1'h1, g, d, 1'h0, 2'h0, 1'h0, 16'h0000);
  endtask
  initial begin
    seed = 41;
    n_fail = 0;
    n_checks = 0;
    resetn = 1'h0;
    repeat (3) @(posedge clk);
    @(negedge clk) resetn = 1'h1;
    repeat (3) @(posedge clk);
    // auto window on a random field, then stepping both ways
    r = 8'($unsigned($random(seed)) % 7) + 8'h01;
    a = {1'h0, r - 8'h01, 7'h00};
    b = 16'($random(seed));
    cmd(1'h0, r, 16'h0000, 1'h0, 2'h2, 1'h1, 16'h0050);
    cmd(1'h1, r, b, 1'h0, 2'h2, 1'h1, 16'h0050);
    rd(8'h09, 16'h0005);
    rd(8'h0a, a);
    wr(8'h0b, b);
    rd(8'h0a, a + 16'h0002);
    wr(8'h0a, a);
    rd(8'h0b, b);
    wr(8'h09, 16'h000a);
    rd(8'h09, 16'h000a);
    wr(8'h0a, a);
    cmd(1'h0, 8'h0b, 16'h0000, 1'h0, 2'h0, 1'h1, b);
    rd(8'h0a, a - 16'h0002);
    $display("test auto window done");
    // second triplet configured by the host
    a = 16'($random(seed));
    b = 16'($random(seed));
    wr(8'h0e, 16'h0005);
    wr(8'h0f, 16'h0100);
    wr(8'h10, a);
    wr(8'h10, b);
    wr(8'h0f, 16'h0100);
    rd(8'h10, a);
    rd(8'h10, b);
    wr(8'h0d, a);
    rd(8'h0d, a);
    wr(8'h08, b);
    rd(8'h08, b);
    $display("test second window done");
    // download preload, auto triplet used meanwhile, refusal while busy
    cmd(1'h1, 8'h14, 16'h0001, 1'h0, 2'h3, 1'h1, 16'h0010);
    check(busy, 1'h1);
    rd(8'h00, 16'h0010);
    rd(8'h0e, 16'h0005);
    rd(8'h0f, 16'h0200);
    cmd(1'h0, 8'h02, 16'h0000, 1'h0, 2'h2, 1'h1, 16'h0050);
    rd(8'h0a, 16'h0080);
    rd(8'h0f, 16'h0200);
    cmd(1'h1, 8'h14, 16'h0001, 1'h0, 2'h1, 1'h0, 16'h0000);
    for (i = 0; i < 200 && busy !== 1'h0; i = i + 1) @(negedge clk);
    check(busy, 1'h0);
    rd(8'h00, 16'h0000);
    rd(8'h14, 16'h0001);
    wr(8'h10, a);
    rd(8'h15, 16'h0002);
    check(host_inst.dat[15], 1'h0);
    $display("test download done");
    // contiguous pair, lower half first
    for (i = 0; i < 3; i = i + 1) begin
      a = 16'($random(seed));
      b = 16'($random(seed));
      c = pv;
      wr(8'h20, a);
      check(pv, c);
      wr(8'h21, b);
      check(pv, {b, a});
      rd(8'h20, a);
      rd(8'h21, b);
    end
    $display("test pair done");
    // previous response, its checksum, armed checking
    rd(8'h13, 16'h0021);
    r = host_inst.ck;
    rd(8'h12, {8'h00, r});
    wr(8'h11, 16'h0000);
    cmd(1'h1, 8'h20, 16'h1234, 1'h1, 2'h1, 1'h0, 16'h0000);
    cmd(1'h1, 8'h20, 16'h1234, 1'h1, 2'h0, 1'h0, 16'h0000);
    wr(8'h11, 16'h0000);
    wr(8'h20, 16'h5678);
    $display("test checksum done");
    // reserved places and wrong-direction accesses
    for (i = 0; i < 4; i = i + 1) begin
      r = (i == 0) ? 8'h0c : (i == 1) ? 8'h16 : (i == 2) ? 8'h1f :
          8'h22 + 8'($unsigned($random(seed)) % 222);
      cmd(1'h0, r, 16'h0000, 1'h0, 2'h1, 1'h0, 16'h0000);
      cmd(1'h1, r, 16'h0000, 1'h0, 2'h1, 1'h0, 16'h0000);
    end
    cmd(1'h1, 8'h12, 16'h0000, 1'h0, 2'h1, 1'h0, 16'h0000);
    cmd(1'h1, 8'h13, 16'h0000, 1'h0, 2'h1, 1'h0, 16'h0000);
    cmd(1'h0, 8'h11, 16'h0000, 1'h0, 2'h1, 1'h0, 16'h0000);
    $display("test reserved done");
    summarize();
  end
endmodule
bind ext_access ext_access_checker #(.FIELD_LEN(FIELD_LEN), .PEND_CYC(PEND_CYC))
  ext_access_checker_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_cmd_valid(i_cmd_valid), .i_cmd_write(i_cmd_write), .i_cmd_reg(i_cmd_reg),
  .i_cmd_data(i_cmd_data), .i_cmd_chk(i_cmd_chk), .o_rsp_valid(o_rsp_valid),
  .o_rsp_status(o_rsp_status), .o_rsp_reg(o_rsp_reg), .o_rsp_data(o_rsp_data),
  .o_rsp_chk(o_rsp_chk), .o_pair_value(o_pair_value), .o_dl_busy(o_dl_busy));
`default_nettype wire
